// ===== rtl/ic_ctrl.sv
// interrupt controller: sensing, enables, priority groups and vectoring
// How it works
// - twenty sources feed twelve vectors, resolved over four priority levels
// - enabled request vectors the core; only higher level preempts running handler
// - dedicated vectors: pin 03, t0 0b, pf 13, t1 1b, rdy 43, radio 4b ...
// - shared vectors: serial 23, timer2 2b, spi/2-wire 53
// - each source sensed by its own polarity or edge
// - wakeup pin seen rising inside; mode config bit 2 picks pin polarity
// - extension bits 5..3 route one of three pins; software sets one only
// - misc request is OR of crystal, converter and random ready
// - radio, wakeup, misc and tick need their wakeup enables
// - enable-low bit 7 is global; zero blocks every interrupt
// - enable-low bit 5 timer2, 4 serial, 0 pin; bit 6 unused
// - enable-high: 7 reload, 5 tick, 4 misc, 2 spi, 1 radio, 0 rdy
// - spi/2-wire share one line, enabled by extension bits 2..0, reset 01
// - six groups, level from bit pairs of two priority registers
// - groups: pin/rdy, t0/radio, pf/spi, t1/wakeup, serial/misc, t2/tick
// - level is high-register bit then low-register bit; 11 is highest
// - flag register holds reload, t2, tick, misc, wakeup, spi, radio, rdy
// - flags 5..1 clear on service; 7, 6 and 0 cleared by software
`timescale 1ns/100ps
`default_nettype none
module ic_ctrl #(
  parameter int GP_PINS = 3
) (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  // special-function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // core vectoring
  input wire logic irq_ack,
  input wire logic irq_return,
  output logic irq_req,
  output logic [15:0] irq_vector,
  output logic [1:0] irq_level,
  output logic [11:0] src_taken,
  // pins
  input wire logic gp_pin_irq_a,
  input wire logic gp_pin_irq_b,
  input wire logic gp_pin_irq_c,
  input wire logic pin_wakeup_irq,
  // on-chip sources
  input wire logic power_fail_irq_n,
  input wire logic timer0_overflow_flag,
  input wire logic timer1_overflow_flag,
  input wire logic timer2_overflow_flag,
  input wire logic timer2_reload_flag,
  input wire logic serial_rx_flag,
  input wire logic serial_tx_flag,
  input wire logic radio_spi_ready_irq,
  input wire logic radio_irq,
  input wire logic master_spi_done,
  input wire logic slave_spi_done,
  input wire logic two_wire_done,
  input wire logic crystal_started_event,
  input wire logic converter_ready_event,
  input wire logic random_ready_event,
  input wire logic low_power_tick_irq,
  // wakeup and mode configuration held elsewhere
  input wire logic wake_en_radio,
  input wire logic wake_en_pin,
  input wire logic wake_en_misc,
  input wire logic wake_en_tick,
  input wire logic wake_pin_active_high
);
  typedef struct packed {
    logic [7:0] irq_enable_low;
    logic [7:0] irq_enable_high;
    logic [7:0] ip0;
    logic [7:0] ip1;
    logic [7:0] exp;
    logic [7:0] flags;
    logic pin_pend;
    logic pf_pend;
    logic pin_prev;
    logic pf_prev;
    logic radio_prev;
    logic wu_prev;
    logic misc_prev;
    logic tick_prev;
    logic tf2_prev;
    logic timer2_reload_flag_prev;
    logic [2:0] spi_prev;
    logic [3:0] insvc;
    logic req;
    logic [15:0] vec;
    logic [1:0] lvl;
    logic [3:0] sel;
    logic [11:0] taken;
    logic [7:0] rdata;
  } ic_state_s;

  localparam ic_state_s IC_RST = '{exp: ic_pkg::IC_RST_EXP, pf_prev: 1'b1, wu_prev: 1'b1, default: '0};

  ic_state_s st_r;
  ic_state_s st_nxt;
  logic [3:0] pins_stable;
  logic pin_fall;
  logic pf_fall;
  logic misc_rise;
  logic [7:0] flag_set;
  logic [11:0] rq;

  if (GP_PINS != 3) begin : g_bad_pins
    $error("ic_ctrl serves exactly three routed pins");
  end

  // pins come from outside the clock domain
  ic_pin_sync #(.WIDTH(4), .STAGES(ic_pkg::IC_SYNC_STAGES), .RST_VAL(4'hf)) u_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .ce(ce),
    .pin_async({pin_wakeup_irq, gp_pin_irq_c, gp_pin_irq_b, gp_pin_irq_a}),
    .pin_stable(pins_stable)
  );

  function automatic logic [1:0] grp_level(input logic [7:0] ip1, input logic [7:0] ip0,
                                           input logic [2:0] g);
    return {ip1[g], ip0[g]};
  endfunction

  // highest level in service: {valid, level}
  function automatic logic [2:0] top_insvc(input logic [3:0] s);
    logic [2:0] t;
    t = 3'h0;
    for (int l = 0; l < ic_pkg::IC_NUM_LEVELS; l++) begin
      if (s[l]) begin
        t = {1'b1, 2'(l)};
      end
    end
    return t;
  endfunction

  always_comb begin
    logic pin_sel;
    logic wu_lvl;
    logic radio_edge;
    logic spi_edge;
    logic wu_rise;
    logic tick_rise;
    logic misc_now;
    logic best_v;
    logic [1:0] best_l;
    logic [3:0] best_i;
    logic [1:0] li;
    logic [2:0] top;
    logic [2:0] spi_now;
    st_nxt = st_r;
    st_nxt.taken = '0;
    // selected pin, active low; software keeps one select bit set
    pin_sel = |(st_r.exp[ic_pkg::IC_EXP_GP_HI:ic_pkg::IC_EXP_GP_LO] & ~pins_stable[2:0]);
    pin_fall = pin_sel & ~st_r.pin_prev;
    pf_fall = st_r.pf_prev & ~power_fail_irq_n;
    wu_lvl = wake_pin_active_high ? pins_stable[3] : ~pins_stable[3];
    wu_rise = wake_en_pin & wu_lvl & ~st_r.wu_prev;
    radio_edge = wake_en_radio & (radio_irq ^ st_r.radio_prev);
    spi_now = {two_wire_done, master_spi_done, slave_spi_done};
    spi_edge = |((spi_now ^ st_r.spi_prev) & st_r.exp[2:0]);
    misc_now = crystal_started_event | converter_ready_event | random_ready_event;
    misc_rise = wake_en_misc & misc_now & ~st_r.misc_prev;
    tick_rise = wake_en_tick & low_power_tick_irq & ~st_r.tick_prev;
    flag_set = {timer2_reload_flag & ~st_r.timer2_reload_flag_prev, timer2_overflow_flag & ~st_r.tf2_prev,
                tick_rise, misc_rise, wu_rise, spi_edge, radio_edge, radio_spi_ready_irq};
    st_nxt.pin_prev = pin_sel;
    st_nxt.pf_prev = power_fail_irq_n;
    st_nxt.wu_prev = wu_lvl;
    st_nxt.radio_prev = radio_irq;
    st_nxt.spi_prev = spi_now;
    st_nxt.misc_prev = misc_now;
    st_nxt.tick_prev = low_power_tick_irq;
    st_nxt.tf2_prev = timer2_overflow_flag;
    st_nxt.timer2_reload_flag_prev = timer2_reload_flag;

    // register writes
    if (sfr_wr) begin
      case (sfr_addr)
        ic_pkg::IC_ADDR_EXP: st_nxt.exp = sfr_wdata & ic_pkg::IC_MASK_EXP;
        ic_pkg::IC_ADDR_IRQ_ENABLE_LOW: st_nxt.irq_enable_low = sfr_wdata & ic_pkg::IC_MASK_IEN;
        ic_pkg::IC_ADDR_IP0: st_nxt.ip0 = sfr_wdata & ic_pkg::IC_MASK_IP;
        ic_pkg::IC_ADDR_IRQ_ENABLE_HIGH: st_nxt.irq_enable_high = sfr_wdata & ic_pkg::IC_MASK_IEN;
        ic_pkg::IC_ADDR_IP1: st_nxt.ip1 = sfr_wdata & ic_pkg::IC_MASK_IP;
        ic_pkg::IC_ADDR_FLAGS: st_nxt.flags = sfr_wdata;
        default: st_nxt.exp = st_nxt.exp;
      endcase
    end

    // vector taken: mark level in service and auto-clear pin, pf and flags 5..1
    if (irq_ack && st_r.req) begin
      st_nxt.insvc[st_r.lvl] = 1'b1;
      st_nxt.taken[st_r.sel] = 1'b1;
      case (st_r.sel)
        ic_pkg::IC_S_PIN: st_nxt.pin_pend = 1'b0;
        ic_pkg::IC_S_PF: st_nxt.pf_pend = 1'b0;
        ic_pkg::IC_S_RADIO: st_nxt.flags[ic_pkg::IC_F_RADIO] = 1'b0;
        ic_pkg::IC_S_SPI: st_nxt.flags[ic_pkg::IC_F_SPI] = 1'b0;
        ic_pkg::IC_S_WU: st_nxt.flags[ic_pkg::IC_F_WU] = 1'b0;
        ic_pkg::IC_S_MISC: st_nxt.flags[ic_pkg::IC_F_MISC] = 1'b0;
        ic_pkg::IC_S_TICK: st_nxt.flags[ic_pkg::IC_F_TICK] = 1'b0;
        default: st_nxt.pin_pend = st_nxt.pin_pend; // timer2, rdy: software clears
      endcase
    end
    top = top_insvc(st_r.insvc);
    if (irq_return && top[2]) begin
      st_nxt.insvc[top[1:0]] = 1'b0;
    end

    // new events win over any clear in the same cycle
    st_nxt.flags = st_nxt.flags | flag_set;
    st_nxt.pin_pend = st_nxt.pin_pend | pin_fall;
    st_nxt.pf_pend = st_nxt.pf_pend | pf_fall;

    // per-vector requests
    rq[ic_pkg::IC_S_PIN] = st_r.pin_pend & st_r.irq_enable_low[ic_pkg::IC_IRQ_ENABLE_LOW_PIN];
    rq[ic_pkg::IC_S_T0] = timer0_overflow_flag & st_r.irq_enable_low[ic_pkg::IC_IRQ_ENABLE_LOW_T0];
    rq[ic_pkg::IC_S_PF] = st_r.pf_pend & st_r.irq_enable_low[ic_pkg::IC_IRQ_ENABLE_LOW_PF];
    rq[ic_pkg::IC_S_T1] = timer1_overflow_flag & st_r.irq_enable_low[ic_pkg::IC_IRQ_ENABLE_LOW_T1];
    rq[ic_pkg::IC_S_SER] = (serial_rx_flag | serial_tx_flag)
                           & st_r.irq_enable_low[ic_pkg::IC_IRQ_ENABLE_LOW_SERIAL];
    rq[ic_pkg::IC_S_T2] = (st_r.flags[ic_pkg::IC_F_TF2] & st_r.irq_enable_low[ic_pkg::IC_IRQ_ENABLE_LOW_T2])
                          | (st_r.flags[ic_pkg::IC_F_TIMER2_RELOAD_FLAG] & st_r.irq_enable_high[ic_pkg::IC_IRQ_ENABLE_HIGH_TIMER2_RELOAD_FLAG]);
    rq[ic_pkg::IC_S_RDY] = st_r.flags[ic_pkg::IC_F_RDY] & st_r.irq_enable_high[ic_pkg::IC_IRQ_ENABLE_HIGH_RDY];
    rq[ic_pkg::IC_S_RADIO] = st_r.flags[ic_pkg::IC_F_RADIO] & st_r.irq_enable_high[ic_pkg::IC_IRQ_ENABLE_HIGH_RADIO];
    rq[ic_pkg::IC_S_SPI] = st_r.flags[ic_pkg::IC_F_SPI] & st_r.irq_enable_high[ic_pkg::IC_IRQ_ENABLE_HIGH_SPI];
    rq[ic_pkg::IC_S_WU] = st_r.flags[ic_pkg::IC_F_WU] & st_r.irq_enable_high[ic_pkg::IC_IRQ_ENABLE_HIGH_WU];
    rq[ic_pkg::IC_S_MISC] = st_r.flags[ic_pkg::IC_F_MISC] & st_r.irq_enable_high[ic_pkg::IC_IRQ_ENABLE_HIGH_MISC];
    rq[ic_pkg::IC_S_TICK] = st_r.flags[ic_pkg::IC_F_TICK] & st_r.irq_enable_high[ic_pkg::IC_IRQ_ENABLE_HIGH_TICK];

    // scan high index to low so a tie leaves the lowest vector
    best_v = 1'b0;
    best_l = 2'h0;
    best_i = 4'h0;
    for (int i = ic_pkg::IC_NUM_SLOTS - 1; i >= 0; i--) begin
      li = grp_level(st_r.ip1, st_r.ip0, ic_pkg::IC_GRP[i]);
      if (rq[i] && (!best_v || li >= best_l)) begin
        best_v = 1'b1;
        best_l = li;
        best_i = 4'(i);
      end
    end
    // held off during the ack cycle so one request gives one vector
    st_nxt.req = st_r.irq_enable_low[ic_pkg::IC_IRQ_ENABLE_LOW_GLOBAL] & best_v
                 & (!top[2] || best_l > top[1:0])
                 & ~(irq_ack & st_r.req);
    st_nxt.vec = ic_pkg::IC_VEC[best_i];
    st_nxt.lvl = best_l;
    st_nxt.sel = best_i;

    // register reads, answer one cycle later, unmapped reads zero
    if (sfr_rd) begin
      case (sfr_addr)
        ic_pkg::IC_ADDR_EXP: st_nxt.rdata = st_r.exp;
        ic_pkg::IC_ADDR_IRQ_ENABLE_LOW: st_nxt.rdata = st_r.irq_enable_low;
        ic_pkg::IC_ADDR_IP0: st_nxt.rdata = st_r.ip0;
        ic_pkg::IC_ADDR_IRQ_ENABLE_HIGH: st_nxt.rdata = st_r.irq_enable_high;
        ic_pkg::IC_ADDR_IP1: st_nxt.rdata = st_r.ip1;
        ic_pkg::IC_ADDR_FLAGS: st_nxt.rdata = st_r.flags;
        default: st_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st_r <= IC_RST;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign sfr_rdata = st_r.rdata;
  assign irq_req = st_r.req;
  assign irq_vector = st_r.vec;
  assign irq_level = st_r.lvl;
  assign src_taken = st_r.taken;

  // checks
  sequence s_ack;
    ce && irq_ack && irq_req;
  endsequence
  sequence s_taken_then_quiet;
    (src_taken != 12'h000) && !irq_req;
  endsequence

  property p_vector;
    @(posedge core_clk) disable iff (!rstn) irq_req |-> irq_vector == ic_pkg::IC_VEC[st_r.sel];
  endproperty
  a_vector: assert property (p_vector) else $error("vector does not match slot");

  property p_global;
    @(posedge core_clk) disable iff (!rstn)
      ce && !st_r.irq_enable_low[ic_pkg::IC_IRQ_ENABLE_LOW_GLOBAL] |=> !irq_req;
  endproperty
  a_global: assert property (p_global) else $error("request with global enable off");

  property p_preempt;
    @(posedge core_clk) disable iff (!rstn)
      irq_req |-> (st_r.insvc == 4'h0) || ({1'b1, irq_level} > top_insvc(st_r.insvc));
  endproperty
  a_preempt: assert property (p_preempt) else $error("request not above level in service");

  property p_ack;
    @(posedge core_clk) disable iff (!rstn) s_ack |=> s_taken_then_quiet;
  endproperty
  a_ack: assert property (p_ack) else $error("ack did not pulse taken and drop request");

  property p_level;
    @(posedge core_clk) disable iff (!rstn)
      ce && $past(ce) && irq_req |->
        irq_level == grp_level($past(st_r.ip1), $past(st_r.ip0), ic_pkg::IC_GRP[st_r.sel]);
  endproperty
  a_level: assert property (p_level) else $error("level not from group bit pair");

  property p_keep_reload;
    @(posedge core_clk) disable iff (!rstn)
      s_ack and (st_r.sel == ic_pkg::IC_S_T2) && st_r.flags[ic_pkg::IC_F_TIMER2_RELOAD_FLAG] && !sfr_wr
      |=> st_r.flags[ic_pkg::IC_F_TIMER2_RELOAD_FLAG];
  endproperty
  a_keep_reload: assert property (p_keep_reload) else $error("reload flag auto-cleared");

  property p_tick_gate;
    @(posedge core_clk) disable iff (!rstn)
      ce && !wake_en_tick && !sfr_wr && !st_r.flags[ic_pkg::IC_F_TICK]
      |=> !st_r.flags[ic_pkg::IC_F_TICK];
  endproperty
  a_tick_gate: assert property (p_tick_gate) else $error("tick flag set while not enabled");

  property p_pin_fall;
    @(posedge core_clk) disable iff (!rstn) ce && pin_fall |=> st_r.pin_pend;
  endproperty
  a_pin_fall: assert property (p_pin_fall) else $error("pin fall not latched");

  property p_misc;
    @(posedge core_clk) disable iff (!rstn) ce && misc_rise |=> st_r.flags[ic_pkg::IC_F_MISC];
  endproperty
  a_misc: assert property (p_misc) else $error("misc event not latched");
endmodule
`default_nettype wire

// ===== rtl/ic_pkg.sv
// constants shared by the interrupt controller files
package ic_pkg;
  // special-function register addresses
  localparam logic [7:0] IC_ADDR_EXP = 8'ha6;
  localparam logic [7:0] IC_ADDR_IRQ_ENABLE_LOW = 8'ha8;
  localparam logic [7:0] IC_ADDR_IP0 = 8'ha9;
  localparam logic [7:0] IC_ADDR_IRQ_ENABLE_HIGH = 8'hb8;
  localparam logic [7:0] IC_ADDR_IP1 = 8'hb9;
  localparam logic [7:0] IC_ADDR_FLAGS = 8'hc0;
  // reset values
  localparam logic [7:0] IC_RST_EXP = 8'h01;
  localparam logic [7:0] IC_RST_REG = 8'h00;
  // writable bits; unused bits read as zero
  localparam logic [7:0] IC_MASK_IEN = 8'hbf;
  localparam logic [7:0] IC_MASK_IP = 8'h3f;
  localparam logic [7:0] IC_MASK_EXP = 8'h3f;
  // field positions
  localparam int IC_IRQ_ENABLE_LOW_GLOBAL = 7;
  localparam int IC_IRQ_ENABLE_LOW_T2 = 5;
  localparam int IC_IRQ_ENABLE_LOW_SERIAL = 4;
  localparam int IC_IRQ_ENABLE_LOW_T1 = 3;
  localparam int IC_IRQ_ENABLE_LOW_PF = 2;
  localparam int IC_IRQ_ENABLE_LOW_T0 = 1;
  localparam int IC_IRQ_ENABLE_LOW_PIN = 0;
  localparam int IC_IRQ_ENABLE_HIGH_TIMER2_RELOAD_FLAG = 7;
  localparam int IC_IRQ_ENABLE_HIGH_TICK = 5;
  localparam int IC_IRQ_ENABLE_HIGH_MISC = 4;
  localparam int IC_IRQ_ENABLE_HIGH_WU = 3;
  localparam int IC_IRQ_ENABLE_HIGH_SPI = 2;
  localparam int IC_IRQ_ENABLE_HIGH_RADIO = 1;
  localparam int IC_IRQ_ENABLE_HIGH_RDY = 0;
  localparam int IC_EXP_GP_LO = 3;
  localparam int IC_EXP_GP_HI = 5;
  localparam int IC_F_TIMER2_RELOAD_FLAG = 7;
  localparam int IC_F_TF2 = 6;
  localparam int IC_F_TICK = 5;
  localparam int IC_F_MISC = 4;
  localparam int IC_F_WU = 3;
  localparam int IC_F_SPI = 2;
  localparam int IC_F_RADIO = 1;
  localparam int IC_F_RDY = 0;
  // vector slots, in fixed polling order
  localparam int IC_NUM_SLOTS = 12;
  localparam logic [3:0] IC_S_PIN = 4'h0;
  localparam logic [3:0] IC_S_T0 = 4'h1;
  localparam logic [3:0] IC_S_PF = 4'h2;
  localparam logic [3:0] IC_S_T1 = 4'h3;
  localparam logic [3:0] IC_S_SER = 4'h4;
  localparam logic [3:0] IC_S_T2 = 4'h5;
  localparam logic [3:0] IC_S_RDY = 4'h6;
  localparam logic [3:0] IC_S_RADIO = 4'h7;
  localparam logic [3:0] IC_S_SPI = 4'h8;
  localparam logic [3:0] IC_S_WU = 4'h9;
  localparam logic [3:0] IC_S_MISC = 4'ha;
  localparam logic [3:0] IC_S_TICK = 4'hb;
  localparam logic [15:0] IC_VEC [0:11] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b,
    16'h0023, 16'h002b, 16'h0043, 16'h004b, 16'h0053, 16'h005b, 16'h0063, 16'h006b};
  localparam logic [2:0] IC_GRP [0:11] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5,
    3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
  localparam int IC_NUM_GROUPS = 6;
  localparam int IC_NUM_LEVELS = 4;
  localparam int IC_SYNC_STAGES = 3;
endpackage

// ===== rtl/ic_pin_sync.sv
// three-flop pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module ic_pin_sync #(
  parameter int WIDTH = 4,
  parameter int STAGES = ic_pkg::IC_SYNC_STAGES,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  // clock and control
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  // pins and filtered levels
  input wire logic [WIDTH-1:0] pin_async,
  output logic [WIDTH-1:0] pin_stable
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] stable;
  } icps_state_s;

  icps_state_s st_r;
  icps_state_s st_nxt;

  if (STAGES != 3) begin : g_bad_stages
    $error("ic_pin_sync supports exactly three stages");
  end

  // s1 feeds only s2; change is taken once s2 and s3 agree
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pin_async;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.stable[i] = st_r.s3[i];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st_r <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, stable: RST_VAL};
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign pin_stable = st_r.stable;
endmodule
`default_nettype wire

// ===== rtl/ic_pkg_end_unused.sv
// holds no code
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ===== dv/ic_core_model.sv
// cpu core stand-in that takes vectors and returns from handlers
`timescale 1ns/100ps
`default_nettype none
module ic_core_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // controller side
  input wire logic irq_req,
  input wire logic [15:0] irq_vector,
  input wire logic [1:0] irq_level,
  output logic irq_ack,
  output logic irq_return,
  // bench control and record
  input wire logic accept,
  input wire logic ret_hold,
  output int taken_cnt,
  output logic [15:0] last_vec,
  output logic [1:0] last_lvl
);
  int depth = 0;
  initial begin
    irq_ack = 1'b0;
    irq_return = 1'b0;
    taken_cnt = 0;
    last_vec = 16'h0000;
    last_lvl = 2'h0;
  end
  // ret_hold keeps a handler open so that preemption can be watched
  always @(negedge core_clk) begin
    if (!rstn) begin
      irq_ack = 1'b0;
      irq_return = 1'b0;
      depth = 0;
    end else if (irq_ack || irq_return) begin
      irq_ack = 1'b0;
      irq_return = 1'b0;
    end else if (accept && irq_req === 1'b1) begin
      irq_ack = 1'b1;
      depth = depth + 1;
      taken_cnt = taken_cnt + 1;
      last_vec = irq_vector;
      last_lvl = irq_level;
    end else if (!ret_hold && depth > 0) begin
      irq_return = 1'b1;
      depth = depth - 1;
    end
  end
endmodule
`default_nettype wire

// ===== dv/tb_mcu_interrupt_controller.sv
// self-checking bench for the interrupt controller
`timescale 1ns/100ps
`default_nettype none
module tb_mcu_interrupt_controller;
  typedef struct packed {
    logic [4:0] id;
    logic [7:0] exp;
    logic [7:0] en0;
    logic [7:0] en1;
    logic [15:0] vec;
    logic [7:0] flg;
  } ic_row_s;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, rd;
  logic sfr_wr = 1'b0, sfr_rd = 1'b0, irq_ack, irq_return, irq_req;
  logic [15:0] irq_vector, last_vec;
  logic [1:0] irq_level, last_lvl;
  logic [11:0] src_taken;
  logic pin_a = 1'b1, pin_b = 1'b1, pin_c = 1'b1, wu_pin = 1'b0, pf_n = 1'b1;
  logic t0 = 1'b0, t1 = 1'b0, t2 = 1'b0, t2r = 1'b0, rx = 1'b0, tx = 1'b0;
  logic rdy = 1'b0, radio = 1'b0, mspi = 1'b0, sspi = 1'b0, twi = 1'b0;
  logic xtal = 1'b0, adc = 1'b0, rng = 1'b0, tick = 1'b0, wu_high = 1'b1;
  logic wen_radio = 1'b1, wen_pin = 1'b1, wen_misc = 1'b1, wen_tick = 1'b1;
  logic accept = 1'b1, ret_hold = 1'b0, ce = 1'b1;
  int taken_cnt, old, err_total = 0, compares = 0;
  logic [7:0] ra [0:5] = '{8'ha6, 8'ha8, 8'ha9, 8'hb8, 8'hb9, 8'ha7};
  logic [7:0] rm [0:5] = '{8'h3f, 8'hbf, 8'h3f, 8'hbf, 8'h3f, 8'h00};
  // id, pin route, enable low, enable high, vector, flags left after service
  ic_row_s rows [0:20] = '{
    '{5'h00, 8'h09, 8'h81, 8'h00, 16'h0003, 8'h00},
    '{5'h01, 8'h07, 8'h82, 8'h00, 16'h000b, 8'h00},
    '{5'h02, 8'h07, 8'h84, 8'h00, 16'h0013, 8'h00},
    '{5'h03, 8'h07, 8'h88, 8'h00, 16'h001b, 8'h00},
    '{5'h04, 8'h07, 8'h90, 8'h00, 16'h0023, 8'h00},
    '{5'h05, 8'h07, 8'h90, 8'h00, 16'h0023, 8'h00},
    '{5'h06, 8'h07, 8'ha0, 8'h00, 16'h002b, 8'h40},
    '{5'h07, 8'h07, 8'h80, 8'h80, 16'h002b, 8'h80},
    '{5'h08, 8'h07, 8'h80, 8'h01, 16'h0043, 8'h01},
    '{5'h09, 8'h07, 8'h80, 8'h02, 16'h004b, 8'h00},
    '{5'h0a, 8'h07, 8'h80, 8'h04, 16'h0053, 8'h00},
    '{5'h0b, 8'h07, 8'h80, 8'h04, 16'h0053, 8'h00},
    '{5'h0c, 8'h07, 8'h80, 8'h04, 16'h0053, 8'h00},
    '{5'h0d, 8'h07, 8'h80, 8'h08, 16'h005b, 8'h00},
    '{5'h0e, 8'h07, 8'h80, 8'h10, 16'h0063, 8'h00},
    '{5'h0f, 8'h07, 8'h80, 8'h10, 16'h0063, 8'h00},
    '{5'h10, 8'h07, 8'h80, 8'h10, 16'h0063, 8'h00},
    '{5'h11, 8'h07, 8'h80, 8'h20, 16'h006b, 8'h00},
    '{5'h12, 8'h11, 8'h81, 8'h00, 16'h0003, 8'h00},
    '{5'h13, 8'h21, 8'h81, 8'h00, 16'h0003, 8'h00},
    '{5'h14, 8'h07, 8'h80, 8'h08, 16'h005b, 8'h00}
  };
  always #12.5 core_clk = ~core_clk;
  ic_ctrl DUT (
    .core_clk(core_clk), .rstn(rstn), .ce(ce), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .irq_ack(irq_ack),
    .irq_return(irq_return), .irq_req(irq_req), .irq_vector(irq_vector),
    .irq_level(irq_level), .src_taken(src_taken), .gp_pin_irq_a(pin_a),
    .gp_pin_irq_b(pin_b), .gp_pin_irq_c(pin_c), .pin_wakeup_irq(wu_pin),
    .power_fail_irq_n(pf_n), .timer0_overflow_flag(t0), .timer1_overflow_flag(t1),
    .timer2_overflow_flag(t2), .timer2_reload_flag(t2r), .serial_rx_flag(rx),
    .serial_tx_flag(tx), .radio_spi_ready_irq(rdy), .radio_irq(radio),
    .master_spi_done(mspi), .slave_spi_done(sspi), .two_wire_done(twi),
    .crystal_started_event(xtal), .converter_ready_event(adc), .random_ready_event(rng),
    .low_power_tick_irq(tick), .wake_en_radio(wen_radio), .wake_en_pin(wen_pin),
    .wake_en_misc(wen_misc), .wake_en_tick(wen_tick), .wake_pin_active_high(wu_high)
  );
  ic_core_model core (
    .core_clk(core_clk), .rstn(rstn), .irq_req(irq_req), .irq_vector(irq_vector),
    .irq_level(irq_level), .irq_ack(irq_ack), .irq_return(irq_return), .accept(accept),
    .ret_hold(ret_hold), .taken_cnt(taken_cnt), .last_vec(last_vec), .last_lvl(last_lvl)
  );
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // extra edge at the end so back-to-back calls never reassign in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    cyc(1);
    sfr_wr = 1'b0;
    cyc(1);
  endtask
  task automatic rdr(input logic [7:0] a);
    sfr_addr = a;
    sfr_rd = 1'b1;
    cyc(1);
    sfr_rd = 1'b0;
    cyc(1);
    rd = sfr_rdata;
  endtask
  task automatic wait_take(input int prev);
    for (int i = 0; i < 40 && taken_cnt == prev; i++) begin
      cyc(1);
    end
    if (taken_cnt == prev) begin
      check("vector taken", 16'h0000, 16'h0001);
      complete_run();
    end
  endtask
  task automatic drive(input logic [4:0] id, input logic act);
    case (id)
      5'h00: pin_a = !act;
      5'h01: t0 = act;
      5'h02: pf_n = !act;
      5'h03: t1 = act;
      5'h04: rx = act;
      5'h05: tx = act;
      5'h06: t2 = act;
      5'h07: t2r = act;
      5'h08: rdy = act;
      5'h09: radio = act;
      5'h0a: mspi = act;
      5'h0b: sspi = act;
      5'h0c: twi = act;
      5'h0d: wu_pin = act;
      5'h0e: xtal = act;
      5'h0f: adc = act;
      5'h10: rng = act;
      5'h11: tick = act;
      5'h12: pin_b = !act;
      5'h13: pin_c = !act;
      default: begin
        wu_high = 1'b0;
        wu_pin = !act;
      end
    endcase
  endtask
  initial begin
    cyc(4);
    rstn = 1'b1;
    cyc(1);
    foreach (rows[i]) begin
      old = taken_cnt;
      wr(8'ha6, rows[i].exp);
      wr(8'hb8, rows[i].en1);
      wr(8'ha8, rows[i].en0);
      drive(rows[i].id, 1'b1);
      wait_take(old);
      check("vector", last_vec, rows[i].vec);
      check("level", {14'h0000, last_lvl}, 16'h0000);
      rdr(8'hc0);
      check("flags", {8'h00, rd}, {8'h00, rows[i].flg});
      wr(8'ha8, 8'h00);
      drive(rows[i].id, 1'b0);
      cyc(6);
      wr(8'hc0, 8'h00);
      cyc(4);
    end
    // global enable off: a pending timer must wait
    old = taken_cnt;
    t0 = 1'b1;
    t1 = 1'b1;
    wr(8'ha8, 8'h0a);
    cyc(12);
    check("masked take", 16'(taken_cnt - old), 16'h0000);
    wr(8'ha8, 8'h8a);
    wait_take(old);
    check("equal level order", last_vec, 16'h000b);
    wr(8'ha8, 8'h00);
    cyc(6);
    old = taken_cnt;
    wr(8'ha9, 8'h08);
    wr(8'hb9, 8'h08);
    wr(8'ha8, 8'h8a);
    wait_take(old);
    check("group level", last_vec, 16'h001b);
    check("level three", {14'h0000, last_lvl}, 16'h0003);
    wr(8'ha8, 8'h00);
    wr(8'ha9, 8'h00);
    wr(8'hb9, 8'h00);
    cyc(6);
    // handler held open: equal level waits, higher level preempts
    ret_hold = 1'b1;
    t1 = 1'b0;
    old = taken_cnt;
    wr(8'ha8, 8'h8a);
    wait_take(old);
    check("first handler", last_vec, 16'h000b);
    t1 = 1'b1;
    old = taken_cnt;
    cyc(12);
    check("no preempt", 16'(taken_cnt - old), 16'h0000);
    wr(8'ha9, 8'h08);
    wait_take(old);
    check("preempt", last_vec, 16'h001b);
    ret_hold = 1'b0;
    t0 = 1'b0;
    t1 = 1'b0;
    wr(8'ha8, 8'h00);
    wr(8'ha9, 8'h00);
    cyc(8);
    // tick without its wakeup enable never sets a flag
    wen_tick = 1'b0;
    old = taken_cnt;
    wr(8'hb8, 8'h20);
    wr(8'ha8, 8'h80);
    tick = 1'b1;
    cyc(10);
    rdr(8'hc0);
    check("gated flag", {8'h00, rd}, 16'h0000);
    check("gated take", 16'(taken_cnt - old), 16'h0000);
    tick = 1'b0;
    wen_tick = 1'b1;
    wr(8'ha8, 8'h00);
    // unused bits and an unmapped address read back as zero
    for (int k = 0; k < 6; k++) begin
      wr(ra[k], 8'hff);
      rdr(ra[k]);
      check("written bits", {8'h00, rd}, {8'h00, rm[k]});
    end
    // clock enable low must freeze a write
    ce = 1'b0;
    wr(8'ha8, 8'h41);
    ce = 1'b1;
    rdr(8'ha8);
    check("frozen write", {8'h00, rd}, 16'h00bf);
    rstn = 1'b0;
    cyc(4);
    check("request in reset", {15'h0000, irq_req}, 16'h0000);
    rstn = 1'b1;
    cyc(1);
    ra[5] = 8'hc0;
    for (int k = 0; k < 6; k++) begin
      rdr(ra[k]);
      check("reset value", {8'h00, rd}, (k == 0) ? 16'h0001 : 16'h0000);
    end
    complete_run();
  end
endmodule
`default_nettype wire
